/* logic/rtc_alarm_repeat_time_date.sv */
`timescale 1ns/1ns
// Function
// - with chime off, the eight-bit repeat count gives count plus one alarm triggers, 256 for all ones.
// - every alarm event while enabled lowers a nonzero repeat count by one.
// - the count wraps from zero to all ones only with chime on, otherwise it stays at zero.
// - an alarm event at count zero with chime off clears the alarm enable bit.
// - the alarm control register is cleared by power-on reset only.
// - hours sit in bcd at bits 29-28 (tens) and 27-24 (units).
// - minutes sit in bcd at bits 22-20 (tens) and 19-16 (units).
// - seconds sit in bcd at bits 14-12 (tens) and 11-8 (units).
// - the low byte and bits 31-30, 23 and 15 of the time word read as zero.
// - time and date words accept writes only while the write unlock bit is set.
// - the year sits in bcd at bits 31-28 (tens) and 27-24 (units).
// - the month sits in bcd with tens at bit 20 and units at bits 19-16.
// - the day of month sits in bcd at bits 13-12 (tens) and 11-8 (units).
// - the weekday 0 to 6 sits at bits 2-0 and the other unused date bits read zero.
module rtc_alarm_repeat_time_date
    import rtc_pkg::*;
#(
    parameter int HALF_SECOND_CYCLES = HALF_SECOND_CYC
)
(
    // clock and power-on reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // other reset sources, synchronous, active low
    input  wire logic        sys_reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // alarm match from the comparator, one-cycle pulse
    input  wire logic        alarm_event,
    // outputs
    output logic             alarm_pulse,
    output logic             irq
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic                  alarm_enable;
    logic                  alarm_chime;
    logic                  alarm_piv;
    logic [3:0]            alarm_mask;
    logic [7:0]            alarm_repeat_count;
    logic                  clock_on;
    logic                  value_write_unlock;
    logic [PRESCALE_W-1:0] prescale;
    logic                  half_phase;
    logic [1:0]            hr_t;
    logic [3:0]            hr_u;
    logic [2:0]            mn_t;
    logic [3:0]            mn_u;
    logic [2:0]            sc_t;
    logic [3:0]            sc_u;
    logic [3:0]            yr_t;
    logic [3:0]            yr_u;
    logic                  mo_t;
    logic [3:0]            mo_u;
    logic [1:0]            dy_t;
    logic [3:0]            dy_u;
    logic [2:0]            wday;
    logic [INT_WIDTH-1:0]  int_status;
    logic [INT_WIDTH-1:0]  int_mask;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire setup      = psel && !penable;
    wire commit     = psel && penable && pready;
    wire wr         = commit && pwrite;
    wire sel_alarm  = (paddr == ALARM_CONTROL_ADDR);
    wire sel_time   = (paddr == TIME_VALUE_ADDR);
    wire sel_date   = (paddr == DATE_VALUE_ADDR);
    wire sel_ctrl   = (paddr == CLOCK_CONTROL_ADDR);
    wire sel_stat   = (paddr == INT_STATUS_ADDR);
    wire sel_mask   = (paddr == INT_MASK_ADDR);
    wire mapped     = sel_alarm || sel_time || sel_date || sel_ctrl || sel_stat || sel_mask;
    wire wr_alarm   = wr && sel_alarm;
    wire wr_time    = wr && sel_time && value_write_unlock;
    wire wr_date    = wr && sel_date && value_write_unlock;
    wire wr_ctrl    = wr && sel_ctrl;
    wire wr_stat    = wr && sel_stat;
    wire wr_mask    = wr && sel_mask;

    // ------------------------------------------------------------
    // half-second prescaler
    // ------------------------------------------------------------
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST  = PRESCALE_W'(HALF_SECOND_CYCLES - 1);
    localparam logic [PRESCALE_W-1:0] PRESCALE_GUARD =
        PRESCALE_W'(HALF_SECOND_CYCLES - READ_GUARD_CYC);

    wire half_tick   = clock_on && (prescale == PRESCALE_LAST);
    wire second_tick = half_tick && half_phase;
    // a read inside the last 32 cycles may straddle the rollover
    wire alarm_read_unsafe = clock_on && (prescale >= PRESCALE_GUARD);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prescale   <= '0;
            half_phase <= 1'h0;
        end else if (wr_time || half_tick) begin
            // a write of the time word restarts the second
            prescale   <= '0;
            half_phase <= wr_time ? 1'h0 : !half_phase;
        end else if (clock_on) begin
            prescale   <= prescale + PRESCALE_W'(1);
        end
    end

    // ------------------------------------------------------------
    // alarm repeat
    // ------------------------------------------------------------
    wire fire        = alarm_event && alarm_enable;
    wire count_zero  = (alarm_repeat_count == REPEAT_ZERO);
    wire auto_off    = fire && count_zero && !alarm_chime;
    // zero wraps to max only with chime, else it holds at zero
    wire [7:0] next_count = !count_zero ? alarm_repeat_count - 8'h01
                          : (alarm_chime ? REPEAT_MAX : REPEAT_ZERO);
    wire [7:0] wr_count  = pwdata[ALARM_COUNT_POS +: 8];
    // power-on reset only: sys_reset_n is deliberately not used here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_enable       <= 1'h0;
            alarm_chime        <= 1'h0;
            alarm_piv          <= 1'h0;
            alarm_mask         <= 4'h0;
            alarm_repeat_count <= REPEAT_ZERO;
        end else begin
            if (wr_alarm) begin
                alarm_chime <= pwdata[ALARM_CHIME_POS];
                alarm_mask  <= pwdata[ALARM_MASK_POS +: 4];
                if (!alarm_enable) begin
                    alarm_piv <= pwdata[ALARM_PIV_POS];
                end
            end
            // for the repeat count and enable bit, a hardware event wins over a bus write in the same cycle
            if (fire) begin
                alarm_repeat_count <= next_count;
                alarm_enable       <= !auto_off;
            end else if (wr_alarm) begin
                alarm_repeat_count <= wr_count;
                alarm_enable       <= pwdata[ALARM_ENABLE_POS];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_pulse <= 1'h0;
        end else begin
            alarm_pulse <= alarm_enable ? (alarm_pulse ^ fire) : alarm_piv;
        end
    end

    // ------------------------------------------------------------
    // clock control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_on           <= 1'h0;
            value_write_unlock <= 1'h0;
        end else if (wr_ctrl) begin
            value_write_unlock <= pwdata[CTRL_UNLOCK_POS];
            if (value_write_unlock) begin
                clock_on <= pwdata[CTRL_ON_POS];
            end
        end
    end

    // ------------------------------------------------------------
    // time and date counters
    // ------------------------------------------------------------
    logic [1:0] n_hr_t;
    logic [3:0] n_hr_u;
    logic [2:0] n_mn_t;
    logic [3:0] n_mn_u;
    logic [2:0] n_sc_t;
    logic [3:0] n_sc_u;
    logic [3:0] n_yr_t;
    logic [3:0] n_yr_u;
    logic       n_mo_t;
    logic [3:0] n_mo_u;
    logic [1:0] n_dy_t;
    logic [3:0] n_dy_u;
    logic [2:0] n_wday;
    logic       day_carry;
    calendar_step u_step (
        .hr_t      (hr_t),
        .hr_u      (hr_u),
        .mn_t      (mn_t),
        .mn_u      (mn_u),
        .sc_t      (sc_t),
        .sc_u      (sc_u),
        .yr_t      (yr_t),
        .yr_u      (yr_u),
        .mo_t      (mo_t),
        .mo_u      (mo_u),
        .dy_t      (dy_t),
        .dy_u      (dy_u),
        .wday      (wday),
        .next_hr_t (n_hr_t),
        .next_hr_u (n_hr_u),
        .next_mn_t (n_mn_t),
        .next_mn_u (n_mn_u),
        .next_sc_t (n_sc_t),
        .next_sc_u (n_sc_u),
        .next_yr_t (n_yr_t),
        .next_yr_u (n_yr_u),
        .next_mo_t (n_mo_t),
        .next_mo_u (n_mo_u),
        .next_dy_t (n_dy_t),
        .next_dy_u (n_dy_u),
        .next_wday (n_wday),
        .day_carry (day_carry)
    );

    // a time write suppresses the date step that the old time would have caused
    wire date_step = second_tick && day_carry && !wr_time;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {hr_t, hr_u, mn_t, mn_u, sc_t, sc_u} <= '0;
        end else if (wr_time) begin
            hr_t <= pwdata[HOURS_TENS_POS +: 2];
            hr_u <= pwdata[HOURS_UNITS_POS +: 4];
            mn_t <= pwdata[MINUTES_TENS_POS +: 3];
            mn_u <= pwdata[MINUTES_UNITS_POS +: 4];
            sc_t <= pwdata[SECONDS_TENS_POS +: 3];
            sc_u <= pwdata[SECONDS_UNITS_POS +: 4];
        end else if (second_tick) begin
            {hr_t, hr_u, mn_t, mn_u, sc_t, sc_u} <=
                {n_hr_t, n_hr_u, n_mn_t, n_mn_u, n_sc_t, n_sc_u};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {yr_t, yr_u, mo_t, mo_u, dy_t, dy_u, wday} <=
                {8'h00, 1'h0, BCD_ONE, 2'h0, BCD_ONE, 3'h0};
        end else if (wr_date) begin
            yr_t <= pwdata[YEAR_TENS_POS +: 4];
            yr_u <= pwdata[YEAR_UNITS_POS +: 4];
            mo_t <= pwdata[MONTH_TENS_POS];
            mo_u <= pwdata[MONTH_UNITS_POS +: 4];
            dy_t <= pwdata[DAY_TENS_POS +: 2];
            dy_u <= pwdata[DAY_UNITS_POS +: 4];
            wday <= pwdata[WEEKDAY_POS +: 3];
        end else if (date_step) begin
            {yr_t, yr_u, mo_t, mo_u, dy_t, dy_u, wday} <=
                {n_yr_t, n_yr_u, n_mo_t, n_mo_u, n_dy_t, n_dy_u, n_wday};
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    wire [INT_WIDTH-1:0] int_set = {auto_off, second_tick, fire};
    wire [INT_WIDTH-1:0] int_clr = wr_stat ? pwdata[INT_WIDTH-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= '0;
            int_mask   <= '0;
            irq        <= 1'h0;
        end else if (!sys_reset_n) begin
            int_status <= '0;
            int_mask   <= '0;
            irq        <= 1'h0;
        end else begin
            // set wins over a clear in the same cycle
            int_status <= (int_status & ~int_clr) | int_set;
            if (wr_mask) begin
                int_mask <= pwdata[INT_WIDTH-1:0];
            end
            irq <= |(int_status & int_mask);
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire [31:0] alarm_word = {16'h0000, alarm_enable, alarm_chime, alarm_piv, alarm_read_unsafe,
                              alarm_mask, alarm_repeat_count};
    wire [31:0] time_word  = {2'h0, hr_t, hr_u, 1'h0, mn_t, mn_u, 1'h0, sc_t, sc_u,
                              8'h00};
    wire [31:0] date_word  = {yr_t, yr_u, 3'h0, mo_t, mo_u, 2'h0, dy_t, dy_u, 5'h00,
                              wday};
    wire [31:0] ctrl_word  = {16'h0000, clock_on, 8'h00, clock_on, 2'h0, value_write_unlock,
                              alarm_read_unsafe, half_phase, 1'h0};
    wire [31:0] rd_mux     = sel_alarm ? alarm_word
                           : sel_time  ? time_word
                           : sel_date  ? date_word
                           : sel_ctrl  ? ctrl_word
                           : sel_stat  ? {29'h0, int_status}
                           : sel_mask  ? {29'h0, int_mask}
                           : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'h0;
            pslverr <= 1'h0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rd_mux;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_repeat_decrement: assert property (
        fire && !count_zero |=> alarm_repeat_count == $past(alarm_repeat_count) - 8'h01)
        else $error("repeat count did not step down by one");
    chk_repeat_wrap: assert property (
        fire && count_zero && alarm_chime |=> alarm_repeat_count == REPEAT_MAX && alarm_enable)
        else $error("repeat count did not wrap to all ones");
    chk_enable_clear: assert property (
        fire && count_zero && !alarm_chime |=> !alarm_enable && count_zero ##1 !fire)
        else $error("alarm enable not cleared at final trigger");
    chk_alarm_por_only: assert property (
        !sys_reset_n && !wr_alarm && !fire |=> $stable(alarm_word[15:0] & 16'hEFFF))
        else $error("alarm control changed under a non power-on reset");
    chk_locked_value: assert property (
        wr && (sel_time || sel_date) && !value_write_unlock && !second_tick
        |=> $stable(time_word) && $stable(date_word))
        else $error("locked value register accepted a write");
    chk_time_zero_bits: assert property (
        pready && sel_time && !pwrite |-> (prdata & 32'hC0808000) == 32'h0 && prdata[7:0] == 8'h00)
        else $error("unused time bits read nonzero");
    chk_date_zero_bits: assert property (
        pready && sel_date && !pwrite |-> (prdata & 32'h00E0C0F8) == 32'h0)
        else $error("unused date bits read nonzero");
    chk_minute_carry: assert property (
        second_tick && !wr_time && sc_u == 4'h9 && sc_t == 3'h5 && mn_u != 4'h9
        |=> sc_u == BCD_ZERO && sc_t == 3'h0 && mn_u == $past(mn_u) + 4'h1)
        else $error("seconds rollover did not carry into minutes");
    chk_day_rollover: assert property (
        second_tick && !wr_time && !wr_date && time_word == 32'h23595900
        |=> {hr_t, hr_u} == 6'h00 && wday != $past(wday))
        else $error("midnight did not clear hours and step the weekday");
    chk_second_period: assert property (
        second_tick |=> !second_tick [*8])
        else $error("second ticks too close together");
    chk_apb_answer: assert property (
        setup |=> pready ##1 !pready || setup)
        else $error("apb answer not exactly one access cycle");
    chk_irq_level: assert property (
        sys_reset_n |=> irq == |($past(int_status) & $past(int_mask)))
        else $error("interrupt level does not follow masked status");

    cov_chime_wrap: cover property (fire && count_zero && alarm_chime);
    cov_auto_off:   cover property (auto_off);
    cov_locked_wr:  cover property (wr && sel_time && !value_write_unlock);
    cov_day_step:   cover property (date_step);

endmodule // rtc_alarm_repeat_time_date

/* logic/rtc_pkg.sv */
package rtc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] ALARM_CONTROL_ADDR = 8'h00;
    localparam logic [7:0] TIME_VALUE_ADDR    = 8'h04;
    localparam logic [7:0] DATE_VALUE_ADDR    = 8'h08;
    localparam logic [7:0] CLOCK_CONTROL_ADDR = 8'h0C;
    localparam logic [7:0] INT_STATUS_ADDR    = 8'h10;
    localparam logic [7:0] INT_MASK_ADDR      = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ALARM_ENABLE_POS  = 15;
    localparam int ALARM_CHIME_POS   = 14;
    localparam int ALARM_PIV_POS     = 13;
    localparam int ALARM_MASK_POS    = 8;
    localparam int ALARM_COUNT_POS   = 0;
    localparam int HOURS_TENS_POS    = 28;
    localparam int HOURS_UNITS_POS   = 24;
    localparam int MINUTES_TENS_POS  = 20;
    localparam int MINUTES_UNITS_POS = 16;
    localparam int SECONDS_TENS_POS  = 12;
    localparam int SECONDS_UNITS_POS = 8;
    localparam int YEAR_TENS_POS     = 28;
    localparam int YEAR_UNITS_POS    = 24;
    localparam int MONTH_TENS_POS    = 20;
    localparam int MONTH_UNITS_POS   = 16;
    localparam int DAY_TENS_POS      = 12;
    localparam int DAY_UNITS_POS     = 8;
    localparam int WEEKDAY_POS       = 0;
    localparam int CTRL_ON_POS       = 15;
    localparam int CTRL_UNLOCK_POS   = 3;
    localparam int INT_ALARM_BIT     = 0;
    localparam int INT_SECOND_BIT    = 1;
    localparam int INT_DISABLE_BIT   = 2;
    localparam int INT_WIDTH         = 3;

    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] REPEAT_MAX       = 8'hFF;
    localparam logic [7:0] REPEAT_ZERO      = 8'h00;
    localparam logic [3:0] BCD_ZERO         = 4'h0;
    localparam logic [3:0] BCD_ONE          = 4'h1;
    localparam int         CLOCK_KHZ        = 125000;
    localparam int         HALF_SECOND_MS   = 500;
    localparam int         HALF_SECOND_CYC  = HALF_SECOND_MS * CLOCK_KHZ;
    localparam int         READ_GUARD_CYC   = 32;
    localparam int         PRESCALE_W       = 26;

endpackage

/* logic/calendar_step.sv */
`timescale 1ns/1ns
// next value of every time and date digit, one second later
module calendar_step
    import rtc_pkg::*;
(
    // current digits
    input  wire logic [1:0] hr_t,
    input  wire logic [3:0] hr_u,
    input  wire logic [2:0] mn_t,
    input  wire logic [3:0] mn_u,
    input  wire logic [2:0] sc_t,
    input  wire logic [3:0] sc_u,
    input  wire logic [3:0] yr_t,
    input  wire logic [3:0] yr_u,
    input  wire logic       mo_t,
    input  wire logic [3:0] mo_u,
    input  wire logic [1:0] dy_t,
    input  wire logic [3:0] dy_u,
    input  wire logic [2:0] wday,
    // next digits
    output logic      [1:0] next_hr_t,
    output logic      [3:0] next_hr_u,
    output logic      [2:0] next_mn_t,
    output logic      [3:0] next_mn_u,
    output logic      [2:0] next_sc_t,
    output logic      [3:0] next_sc_u,
    output logic      [3:0] next_yr_t,
    output logic      [3:0] next_yr_u,
    output logic            next_mo_t,
    output logic      [3:0] next_mo_u,
    output logic      [1:0] next_dy_t,
    output logic      [3:0] next_dy_u,
    output logic      [2:0] next_wday,
    output logic            day_carry
);
    wire sc_u9   = (sc_u == 4'h9);
    wire mn_c    = sc_u9 && (sc_t == 3'h5);
    wire hr_c    = mn_c && (mn_u == 4'h9) && (mn_t == 3'h5);
    wire hr_last = (hr_t == 2'h2) && (hr_u == 4'h3);
    wire dy_c    = hr_c && hr_last;
    // leap year every fourth year of the two-digit century
    wire leap    = yr_t[0] ? ((yr_u == 4'h2) || (yr_u == 4'h6))
                           : ((yr_u == 4'h0) || (yr_u == 4'h4) || (yr_u == 4'h8));
    wire [4:0] mo_bcd = {mo_t, mo_u};
    wire is_feb  = (mo_bcd == 5'h02);
    wire is_30   = (mo_bcd == 5'h04) || (mo_bcd == 5'h06) || (mo_bcd == 5'h09)
                || (mo_bcd == 5'h11);
    wire [5:0] last_day = is_feb ? (leap ? 6'h29 : 6'h28) : (is_30 ? 6'h30 : 6'h31);
    wire dy_last = ({dy_t, dy_u} == last_day);
    wire mo_c    = dy_c && dy_last;
    wire mo_last = (mo_bcd == 5'h12);
    wire yr_c    = mo_c && mo_last;

    assign day_carry = dy_c;
    assign next_sc_u = sc_u9 ? BCD_ZERO : sc_u + 4'h1;
    assign next_sc_t = sc_u9 ? (mn_c ? 3'h0 : sc_t + 3'h1) : sc_t;
    assign next_mn_u = !mn_c ? mn_u : ((mn_u == 4'h9) ? BCD_ZERO : mn_u + 4'h1);
    assign next_mn_t = !(mn_c && (mn_u == 4'h9)) ? mn_t : (hr_c ? 3'h0 : mn_t + 3'h1);
    assign next_hr_u = !hr_c ? hr_u : ((hr_last || hr_u == 4'h9) ? BCD_ZERO : hr_u + 4'h1);
    assign next_hr_t = !hr_c ? hr_t : (hr_last ? 2'h0 : ((hr_u == 4'h9) ? hr_t + 2'h1 : hr_t));
    assign next_wday = !dy_c ? wday : ((wday == 3'h6) ? 3'h0 : wday + 3'h1);
    assign next_dy_u = !dy_c ? dy_u : (dy_last ? BCD_ONE
                                     : ((dy_u == 4'h9) ? BCD_ZERO : dy_u + 4'h1));
    assign next_dy_t = !dy_c ? dy_t : (dy_last ? 2'h0
                                     : ((dy_u == 4'h9) ? dy_t + 2'h1 : dy_t));
    assign next_mo_u = !mo_c ? mo_u : (mo_last ? BCD_ONE
                                     : ((mo_u == 4'h9) ? BCD_ZERO : mo_u + 4'h1));
    assign next_mo_t = !mo_c ? mo_t : (mo_last ? 1'h0 : ((mo_u == 4'h9) ? 1'h1 : mo_t));
    assign next_yr_u = !yr_c ? yr_u : ((yr_u == 4'h9) ? BCD_ZERO : yr_u + 4'h1);
    assign next_yr_t = !(yr_c && yr_u == 4'h9) ? yr_t
                     : ((yr_t == 4'h9) ? BCD_ZERO : yr_t + 4'h1);
endmodule // calendar_step

/* test/rtc_alarm_repeat_time_date_test.sv */
`timescale 1ns/1ns
module rtc_alarm_repeat_time_date_test
    import rtc_pkg::*;
;
    logic        pclk = '0, presetn = '0, sys_reset_n = '1, alarm_event = '0;
    logic        psel = '0, penable = '0, pwrite = '0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic        pready, pslverr, err, alarm_pulse, irq;
    int          num_errors = 0, n_tests = 0;
    always #4 pclk = ~pclk;
    rtc_alarm_repeat_time_date #(.HALF_SECOND_CYCLES(100)) dut (.pclk(pclk),
        .presetn(presetn), .sys_reset_n(sys_reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alarm_event(alarm_event), .alarm_pulse(alarm_pulse), .irq(irq));
    // ----
    // helpers
    // ----
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) begin
            num_errors++;
            tally_and_finish;
        end
        @(posedge pclk);
    endtask
    task automatic ev;
        alarm_event <= 1'h1;
        @(posedge pclk);
        alarm_event <= 1'h0;
        repeat (2) @(posedge pclk);
    endtask
    // piv and unsafe follow live state, so they are masked off
    task automatic alarm_rd(input string nm, input logic [31:0] exp);
        apb(1'h0, ALARM_CONTROL_ADDR, '0);
        chk(nm, exp, rd & 32'h0000CFFF);
    endtask
    // ----
    // scenarios
    // ----
    task automatic time_date_scn;
        apb(1'h1, TIME_VALUE_ADDR, 32'h12345600);
        apb(1'h0, TIME_VALUE_ADDR, '0);
        chk("locked time", 32'h00000000, rd);
        apb(1'h1, CLOCK_CONTROL_ADDR, 32'h00000008);
        apb(1'h1, DATE_VALUE_ADDR, 32'h99F2F1FE);
        apb(1'h0, DATE_VALUE_ADDR, '0);
        chk("date fields", 32'h99123106, rd);
        apb(1'h1, TIME_VALUE_ADDR, 32'hE3D9D9FF);
        apb(1'h0, TIME_VALUE_ADDR, '0);
        chk("time fields", 32'h23595900, rd);
        apb(1'h1, CLOCK_CONTROL_ADDR, 32'h00008008);
        repeat (250) @(posedge pclk);
        apb(1'h0, TIME_VALUE_ADDR, '0);
        chk("midnight time", 32'h00000000, rd);
        apb(1'h0, DATE_VALUE_ADDR, '0);
        chk("new year date", 32'h00010100, rd);
        apb(1'h1, CLOCK_CONTROL_ADDR, 32'h00000008);
    endtask
    task automatic alarm_scn;
        apb(1'h1, ALARM_CONTROL_ADDR, 32'h00008001);
        ev;
        alarm_rd("count down", 32'h00008000);
        chk("pulse toggled", 32'h1, {31'h0, alarm_pulse});
        ev;
        alarm_rd("auto disable", 32'h00000000);
        apb(1'h1, ALARM_CONTROL_ADDR, 32'h00002000);
        @(posedge pclk);
        chk("pulse initial", 32'h1, {31'h0, alarm_pulse});
        apb(1'h1, ALARM_CONTROL_ADDR, 32'h0000C000);
        ev;
        alarm_rd("chime wrap", 32'h0000C0FF);
        chk("pulse wrap", 32'h0, {31'h0, alarm_pulse});
        ev;
        alarm_rd("chime down", 32'h0000C0FE);
    endtask
    task automatic irq_reset_scn;
        apb(1'h0, INT_STATUS_ADDR, '0);
        chk("status", 32'h00000005, rd & 32'h00000005);
        apb(1'h1, INT_MASK_ADDR, 32'h00000004);
        @(posedge pclk);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'h1, INT_STATUS_ADDR, 32'h00000004);
        @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        sys_reset_n <= 1'h0;
        @(posedge pclk);
        sys_reset_n <= 1'h1;
        @(posedge pclk);
        alarm_rd("alarm kept", 32'h0000C0FE);
        apb(1'h0, 8'h18, '0);
        chk("unmapped", 32'h1, {31'h0, err});
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        time_date_scn;
        alarm_scn;
        irq_reset_scn;
        tally_and_finish;
    end
endmodule // rtc_alarm_repeat_time_date_test
